// ### design/plc_mode_ctrl.v
`timescale 1ns/1ps
`include "plc_regs.vh"

module plc_mode_ctrl #(
	parameter        EXTENDED   = 0,
	parameter [15:0] PROG_WORDS = 16'h0800
) (
	input  wire        mclk_in,
	input  wire        resetn_in,
	input  wire        mode_sw_run_in,
	input  wire        cmd_valid_in,
	input  wire [3:0]  cmd_code_in,
	input  wire        diag_fault_in,
	input  wire [7:0]  fault_cause_in,
	input  wire        missing_hw_in,
	input  wire [15:0] ee_rdata_in,
	input  wire [15:0] ram_rdata_in,
	output reg         cmd_accept_out,
	output reg         cmd_reject_out,
	output reg         mode_run_out,
	output reg         mode_halt_out,
	output reg         mode_error_out,
	output reg         mode_hold_out,
	output reg         mode_runf_out,
	output reg         exec_enable_out,
	output reg         io_update_out,
	output reg         outputs_off_out,
	output reg         tool_output_write_out,
	output reg         prog_edit_enable_out,
	output reg  [7:0]  error_cause_out,
	output reg         nvm_busy_out,
	output reg  [15:0] saved_data_count_out,
	output wire        nvm_wear_alarm_flag_out,
	output wire [16:0] wear_count_out,
	output wire        ee_re_out,
	output wire        ee_we_out,
	output wire [15:0] ee_addr_out,
	output wire [15:0] ee_wdata_out,
	output wire        ram_re_out,
	output wire        ram_we_out,
	output wire [15:0] ram_addr_out,
	output wire [15:0] ram_wdata_out
);

	// ==================================================
	// states
	localparam [5:0] M_BOOT  = 6'h01;
	localparam [5:0] M_RUN   = 6'h02;
	localparam [5:0] M_HALT  = 6'h04;
	localparam [5:0] M_ERROR = 6'h08;
	localparam [5:0] M_HOLD  = 6'h10;
	localparam [5:0] M_RUNF  = 6'h20;

	localparam [3:0] SQ_IDLE = 4'h1;
	localparam [3:0] SQ_PROG = 4'h2;
	localparam [3:0] SQ_SET  = 4'h4;
	localparam [3:0] SQ_DATA = 4'h8;

	reg  [5:0]  mode_reg;
	reg  [5:0]  mode_next;
	reg  [3:0]  seq_reg;
	reg         sw_meta_reg;
	reg         sw_run_reg;
	reg         sw_ack_reg;
	reg         boot_kick_reg;
	reg         prog_only_reg;
	reg         mv_start_reg;
	reg         mv_dir_reg;
	reg  [15:0] mv_ee_base_reg;
	reg  [15:0] mv_ram_base_reg;
	reg  [15:0] mv_len_reg;
	reg         legal;
	reg         mode_cmd;
	reg  [5:0]  target;
	wire        mv_done;
	wire [15:0] mv_last;

	wire in_run   = (mode_reg == M_RUN);
	wire in_halt  = (mode_reg == M_HALT);
	wire in_error = (mode_reg == M_ERROR);
	wire in_hold  = (mode_reg == M_HOLD);
	wire in_runf  = (mode_reg == M_RUNF);
	wire in_boot  = (mode_reg == M_BOOT);
	wire seq_idle = (seq_reg == SQ_IDLE) && !boot_kick_reg;

	// ==================================================
	// fault detection
	// missing hardware faults only plain run
	wire hw_fault  = missing_hw_in && in_run;
	wire fault_now = diag_fault_in || hw_fault;

	// ==================================================
	// command decode
	always @* begin
		legal    = 1'b0;
		mode_cmd = 1'b1;
		target   = mode_reg;
		case (cmd_code_in)
			`CMD_RUN: begin
				legal  = in_halt || in_runf;
				target = M_RUN;
			end
			`CMD_HALT: begin
				legal  = in_run || in_runf || in_hold;
				target = M_HALT;
			end
			`CMD_RUNF: begin
				legal  = in_halt || in_run;
				target = M_RUNF;
			end
			`CMD_HOLD: begin
				legal  = in_run || in_runf;
				target = M_HOLD;
			end
			`CMD_HOLD_CANCEL: begin
				legal  = in_hold;
				target = M_RUN;
			end
			`CMD_ERR_RESET: begin
				legal  = in_error;
				target = M_HALT;
			end
			`CMD_EE_READ: begin
				mode_cmd = 1'b0;
				legal    = in_halt && seq_idle;
			end
			`CMD_EE_WRITE: begin
				mode_cmd = 1'b0;
				if (EXTENDED != 0)
					legal = seq_idle && !in_error && !in_boot;
				else
					legal = seq_idle && in_halt;
			end
			`CMD_PROG_LOAD: begin
				mode_cmd = 1'b0;
				legal    = in_halt;
			end
			`CMD_PROG_EDIT: begin
				mode_cmd = 1'b0;
				legal    = in_halt || ((EXTENDED != 0) && in_run);
			end
			default: begin
				mode_cmd = 1'b0;
				legal    = 1'b0;
			end
		endcase
		// mode commands need switch at run
		if (mode_cmd)
			legal = legal && sw_run_reg && seq_idle;
	end

	wire accept     = cmd_valid_in && legal;
	wire ee_rd_go   = accept && (cmd_code_in == `CMD_EE_READ);
	// eeprom changes only through this command
	wire ee_wr_go   = accept && (cmd_code_in == `CMD_EE_WRITE);
	wire seq_finish = mv_done && ((seq_reg == SQ_DATA) ||
		((seq_reg == SQ_PROG) && prog_only_reg));
	wire boot_done  = seq_finish && in_boot;
	// switch moves are deferred while a copy is running
	wire sw_moved   = (sw_run_reg != sw_ack_reg) && seq_idle;

	// ==================================================
	// mode transitions
	always @* begin
		mode_next = mode_reg;
		if (fault_now)
			mode_next = M_ERROR;
		else if (in_error) begin
			if (accept && mode_cmd)
				mode_next = target;
		end else if (boot_done)
			mode_next = sw_run_reg ? M_RUN : M_HALT;
		else if (in_boot)
			mode_next = M_BOOT;
		else if (sw_moved)
			mode_next = sw_run_reg ? M_RUN : M_HALT;
		else if (accept && mode_cmd)
			mode_next = target;
	end

	// ==================================================
	// switch synchroniser and mode register
	always @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sw_meta_reg <= 1'b0;
			sw_run_reg  <= 1'b0;
			sw_ack_reg  <= 1'b0;
			mode_reg    <= M_BOOT;
		end else begin
			sw_meta_reg <= mode_sw_run_in;
			sw_run_reg  <= sw_meta_reg;
			mode_reg    <= mode_next;
			// error and boot swallow switch moves
			if (boot_done || in_error || in_boot || sw_moved)
				sw_ack_reg <= sw_run_reg;
		end
	end

	// ==================================================
	// registered mode outputs
	always @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_accept_out        <= 1'b0;
			cmd_reject_out        <= 1'b0;
			mode_run_out          <= 1'b0;
			mode_halt_out         <= 1'b0;
			mode_error_out        <= 1'b0;
			mode_hold_out         <= 1'b0;
			mode_runf_out         <= 1'b0;
			exec_enable_out       <= 1'b0;
			io_update_out         <= 1'b0;
			outputs_off_out       <= 1'b1;
			tool_output_write_out <= 1'b0;
			prog_edit_enable_out  <= 1'b0;
			error_cause_out       <= `CAUSE_NONE;
		end else begin
			cmd_accept_out <= accept;
			cmd_reject_out <= cmd_valid_in && !legal;
			mode_run_out   <= (mode_next == M_RUN);
			mode_halt_out  <= (mode_next == M_HALT);
			mode_error_out <= (mode_next == M_ERROR);
			mode_hold_out  <= (mode_next == M_HOLD);
			mode_runf_out  <= (mode_next == M_RUNF);
			exec_enable_out <= (mode_next == M_RUN) || (mode_next == M_RUNF);
			io_update_out <= (mode_next == M_RUN) || (mode_next == M_RUNF) ||
				(mode_next == M_HOLD);
			tool_output_write_out <= (mode_next == M_HOLD);
			// halt, error and boot force outputs off
			outputs_off_out <= (mode_next == M_HALT) || (mode_next == M_ERROR) ||
				(mode_next == M_BOOT);
			prog_edit_enable_out <= (mode_next == M_HALT) ||
				((EXTENDED != 0) && (mode_next == M_RUN));
			// first cause held for the tool
			if (fault_now && !in_error)
				error_cause_out <= diag_fault_in ? fault_cause_in : `CAUSE_MISSING_HW;
			else if (in_error && accept && mode_cmd && !fault_now)
				error_cause_out <= `CAUSE_NONE;
		end
	end

	// ==================================================
	// count clamp
	function [15:0] clamp_count;
		input [15:0] raw;
		begin
			clamp_count = (raw > `EXT_DATA_MAX) ? `EXT_DATA_MAX : raw;
		end
	endfunction

	// ==================================================
	// image sequencer: program, settings (extended only), data
	always @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seq_reg              <= SQ_IDLE;
			boot_kick_reg        <= 1'b1;
			prog_only_reg        <= 1'b0;
			mv_start_reg         <= 1'b0;
			mv_dir_reg           <= 1'b0;
			mv_ee_base_reg       <= `EE_PROG_BASE;
			mv_ram_base_reg      <= `RAM_PROG_BASE;
			mv_len_reg           <= 16'h0000;
			nvm_busy_out         <= 1'b1;
			saved_data_count_out <= 16'h0000;
		end else begin
			mv_start_reg <= 1'b0;
			nvm_busy_out <= !seq_finish && (!seq_idle || ee_rd_go || ee_wr_go);
			case (seq_reg)
				SQ_IDLE: begin
					// power-on load, same path as read
					if (boot_kick_reg || ee_rd_go || ee_wr_go) begin
						boot_kick_reg   <= 1'b0;
						prog_only_reg   <= ee_wr_go && (EXTENDED != 0) && in_run;
						mv_dir_reg      <= ee_wr_go;
						mv_ee_base_reg  <= `EE_PROG_BASE;
						mv_ram_base_reg <= `RAM_PROG_BASE;
						mv_len_reg      <= PROG_WORDS;
						mv_start_reg    <= 1'b1;
						seq_reg         <= SQ_PROG;
					end
				end
				SQ_PROG: begin
					if (mv_done) begin
						if (prog_only_reg)
							seq_reg <= SQ_IDLE;
						else if (EXTENDED != 0) begin
							mv_ee_base_reg  <= PROG_WORDS;
							mv_ram_base_reg <= `RAM_SET_BASE;
							mv_len_reg      <= `SET_WORDS;
							mv_start_reg    <= 1'b1;
							seq_reg         <= SQ_SET;
						end else begin
							mv_ee_base_reg       <= PROG_WORDS;
							mv_ram_base_reg      <= `RAM_DATA_BASE;
							mv_len_reg           <= `STD_DATA_WORDS;
							saved_data_count_out <= `STD_DATA_WORDS;
							mv_start_reg         <= 1'b1;
							seq_reg              <= SQ_DATA;
						end
					end
				end
				SQ_SET: begin
					if (mv_done) begin
						// count word moved last sizes the data
						mv_ee_base_reg       <= PROG_WORDS + `SET_WORDS;
						mv_ram_base_reg      <= `RAM_DATA_BASE;
						mv_len_reg           <= clamp_count(mv_last);
						saved_data_count_out <= clamp_count(mv_last);
						mv_start_reg         <= 1'b1;
						seq_reg              <= SQ_DATA;
					end
				end
				SQ_DATA: begin
					if (mv_done)
						seq_reg <= SQ_IDLE;
				end
				default: seq_reg <= SQ_IDLE;
			endcase
		end
	end

	// ==================================================
	// datapath and wear counter
	nvm_mover u_mover (
		.mclk_in       (mclk_in),
		.resetn_in     (resetn_in),
		.start_in      (mv_start_reg),
		.dir_in        (mv_dir_reg),
		.ee_base_in    (mv_ee_base_reg),
		.ram_base_in   (mv_ram_base_reg),
		.len_in        (mv_len_reg),
		.ee_rdata_in   (ee_rdata_in),
		.ram_rdata_in  (ram_rdata_in),
		.done_out      (mv_done),
		.last_word_out (mv_last),
		.ee_re_out     (ee_re_out),
		.ee_we_out     (ee_we_out),
		.ee_addr_out   (ee_addr_out),
		.ee_wdata_out  (ee_wdata_out),
		.ram_re_out    (ram_re_out),
		.ram_we_out    (ram_we_out),
		.ram_addr_out  (ram_addr_out),
		.ram_wdata_out (ram_wdata_out)
	);

	nvm_wear u_wear (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.write_in  (ee_wr_go),
		.count_out (wear_count_out),
		.alarm_out (nvm_wear_alarm_flag_out)
	);

endmodule // plc_mode_ctrl

// ### design/plc_regs.vh
`ifndef PLC_REGS_VH
`define PLC_REGS_VH

// ==================================================
// tool command codes
`define CMD_RUN          4'h1
`define CMD_HALT         4'h2
`define CMD_RUNF         4'h3
`define CMD_HOLD         4'h4
`define CMD_HOLD_CANCEL  4'h5
`define CMD_ERR_RESET    4'h6
`define CMD_EE_READ      4'h7
`define CMD_EE_WRITE     4'h8
`define CMD_PROG_LOAD    4'h9
`define CMD_PROG_EDIT    4'ha

// ==================================================
// nonvolatile image layout
`define EE_PROG_BASE     16'h0000
`define RAM_PROG_BASE    16'h0000
`define RAM_SET_BASE     16'h8000
`define RAM_DATA_BASE    16'h9000
// settings block: tool port x3, serial port x2, count last
`define SET_WORDS        16'h0006
`define STD_DATA_WORDS   16'h0200
`define EXT_DATA_MAX     16'h0800

// ==================================================
// wear and error causes
`define WEAR_LIMIT       17'h186a0
`define WEAR_RESET       17'h00000
`define CAUSE_NONE       8'h00
`define CAUSE_MISSING_HW 8'h01

`endif

// ### design/nvm_mover.v
`timescale 1ns/1ps
`include "plc_regs.vh"

// ==================================================
// block copy between eeprom and ram, sync read latency 1
module nvm_mover (
	input  wire        mclk_in,
	input  wire        resetn_in,
	input  wire        start_in,
	input  wire        dir_in,
	input  wire [15:0] ee_base_in,
	input  wire [15:0] ram_base_in,
	input  wire [15:0] len_in,
	input  wire [15:0] ee_rdata_in,
	input  wire [15:0] ram_rdata_in,
	output reg         done_out,
	output reg  [15:0] last_word_out,
	output reg         ee_re_out,
	output reg         ee_we_out,
	output reg  [15:0] ee_addr_out,
	output reg  [15:0] ee_wdata_out,
	output reg         ram_re_out,
	output reg         ram_we_out,
	output reg  [15:0] ram_addr_out,
	output reg  [15:0] ram_wdata_out
);

	reg        busy_reg;
	reg        pend_reg;
	reg [15:0] rcnt_reg;
	reg [15:0] wcnt_reg;
	reg [15:0] roff_reg;
	reg [15:0] woff_reg;
	wire [15:0] src_data = dir_in ? ram_rdata_in : ee_rdata_in;
	wire        issue    = busy_reg && (rcnt_reg != 16'h0000);

	always @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_reg      <= 1'b0;
			pend_reg      <= 1'b0;
			rcnt_reg      <= 16'h0000;
			wcnt_reg      <= 16'h0000;
			roff_reg      <= 16'h0000;
			woff_reg      <= 16'h0000;
			done_out      <= 1'b0;
			last_word_out <= 16'h0000;
			ee_re_out     <= 1'b0;
			ee_we_out     <= 1'b0;
			ee_addr_out   <= 16'h0000;
			ee_wdata_out  <= 16'h0000;
			ram_re_out    <= 1'b0;
			ram_we_out    <= 1'b0;
			ram_addr_out  <= 16'h0000;
			ram_wdata_out <= 16'h0000;
		end else begin
			done_out   <= 1'b0;
			ee_re_out  <= 1'b0;
			ee_we_out  <= 1'b0;
			ram_re_out <= 1'b0;
			ram_we_out <= 1'b0;
			// data is valid one edge after the read was registered
			pend_reg   <= ee_re_out | ram_re_out;
			if (start_in && !busy_reg) begin
				busy_reg <= (len_in != 16'h0000);
				done_out <= (len_in == 16'h0000);
				rcnt_reg <= len_in;
				wcnt_reg <= len_in;
				roff_reg <= 16'h0000;
				woff_reg <= 16'h0000;
			end else begin
				if (issue) begin
					if (dir_in) begin
						ram_re_out   <= 1'b1;
						ram_addr_out <= ram_base_in + roff_reg;
					end else begin
						ee_re_out   <= 1'b1;
						ee_addr_out <= ee_base_in + roff_reg;
					end
					roff_reg <= roff_reg + 16'h0001;
					rcnt_reg <= rcnt_reg - 16'h0001;
				end
				if (pend_reg) begin
					if (dir_in) begin
						ee_we_out    <= 1'b1;
						ee_addr_out  <= ee_base_in + woff_reg;
						ee_wdata_out <= src_data;
					end else begin
						ram_we_out    <= 1'b1;
						ram_addr_out  <= ram_base_in + woff_reg;
						ram_wdata_out <= src_data;
					end
					last_word_out <= src_data;
					woff_reg      <= woff_reg + 16'h0001;
					wcnt_reg      <= wcnt_reg - 16'h0001;
					if (wcnt_reg == 16'h0001) begin
						busy_reg <= 1'b0;
						done_out <= 1'b1;
					end
				end
			end
		end
	end

endmodule // nvm_mover

// ### design/nvm_wear.v
`timescale 1ns/1ps
`include "plc_regs.vh"

// ==================================================
// write counter, saturating so the alarm never drops
module nvm_wear (
	input  wire        mclk_in,
	input  wire        resetn_in,
	input  wire        write_in,
	output reg  [16:0] count_out,
	output reg         alarm_out
);

	always @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_out <= `WEAR_RESET;
			alarm_out <= 1'b0;
		end else begin
			if (write_in && (count_out != 17'h1ffff))
				count_out <= count_out + 17'h00001;
			alarm_out <= (count_out > `WEAR_LIMIT);
		end
	end

endmodule // nvm_wear

// ### tb/nvm_store_model.sv
`timescale 1ns/1ps

// ==================================================
// eeprom and ram behind the copy engine, read latency 1
module nvm_store_model (
	input  wire        mclk_in,
	input  wire        ee_re_in,
	input  wire        ee_we_in,
	input  wire [15:0] ee_addr_in,
	input  wire [15:0] ee_wdata_in,
	input  wire        ram_re_in,
	input  wire        ram_we_in,
	input  wire [15:0] ram_addr_in,
	input  wire [15:0] ram_wdata_in,
	output reg  [15:0] ee_rdata_out,
	output reg  [15:0] ram_rdata_out
);
	logic [15:0] ee  [0:65535];
	logic [15:0] ram [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) begin
			ee[i] = i[15:0] ^ 16'ha5c3;
			ram[i] = 16'h0000;
		end
		ee_rdata_out = 16'h0000;
		ram_rdata_out = 16'h0000;
	end
	// image kept here
	// idle data lines flip so a stale word never looks valid
	always @(posedge mclk_in) begin
		if (ee_we_in)
			ee[ee_addr_in] <= ee_wdata_in;
		if (ram_we_in)
			ram[ram_addr_in] <= ram_wdata_in;
		ee_rdata_out <= ee_re_in ? ee[ee_addr_in] : ~ee_rdata_out;
		ram_rdata_out <= ram_re_in ? ram[ram_addr_in] : ~ram_rdata_out;
	end
endmodule // nvm_store_model

// ### tb/plc_mode_ctrl_monitor.sv
`timescale 1ns/1ps
`include "plc_regs.vh"

// ==================================================
// port-level checks
module plc_mode_ctrl_monitor #(
	parameter EXTENDED = 0
) (
	input wire        mclk_in,
	input wire        resetn_in,
	input wire        cmd_valid_in,
	input wire [3:0]  cmd_code_in,
	input wire        diag_fault_in,
	input wire [15:0] ee_rdata_in,
	input wire        cmd_accept_out,
	input wire        cmd_reject_out,
	input wire        mode_run_out,
	input wire        mode_halt_out,
	input wire        mode_error_out,
	input wire        mode_hold_out,
	input wire        mode_runf_out,
	input wire        exec_enable_out,
	input wire        io_update_out,
	input wire        outputs_off_out,
	input wire        tool_output_write_out,
	input wire        nvm_busy_out,
	input wire        nvm_wear_alarm_flag_out,
	input wire [16:0] wear_count_out,
	input wire        ee_re_out,
	input wire        ram_we_out,
	input wire [15:0] ram_wdata_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	AST_ONE_ANSWER: assert property (cmd_valid_in |=> cmd_accept_out ^ cmd_reject_out)
		else $error("command not answered exactly once");
	AST_NO_SPURIOUS: assert property (!cmd_valid_in |=> !cmd_accept_out && !cmd_reject_out)
		else $error("answer without command");
	AST_FAULT_ERROR: assert property (diag_fault_in |=> mode_error_out)
		else $error("fault did not enter error");
	AST_ERROR_OFF: assert property (mode_error_out |-> outputs_off_out && !exec_enable_out)
		else $error("error mode with live outputs");
	AST_HALT_OFF: assert property (mode_halt_out |-> outputs_off_out && !exec_enable_out)
		else $error("halt mode with live outputs");
	AST_HOLD_IO: assert property (mode_hold_out |-> io_update_out && tool_output_write_out && !exec_enable_out)
		else $error("hold mode io wrong");
	AST_RUN_EXEC: assert property ((mode_run_out || mode_runf_out) |-> exec_enable_out && io_update_out && !outputs_off_out)
		else $error("run mode not executing");
	AST_LOAD_HALT: assert property (cmd_valid_in && cmd_code_in == `CMD_PROG_LOAD && !mode_halt_out |=> cmd_reject_out)
		else $error("program load taken outside halt");
	AST_READ_HALT: assert property (cmd_valid_in && cmd_code_in == `CMD_EE_READ && !(mode_halt_out && !nvm_busy_out) |=> cmd_reject_out)
		else $error("eeprom read taken outside halt");
	AST_WRITE_STD: assert property (EXTENDED == 0 && cmd_valid_in && cmd_code_in == `CMD_EE_WRITE && !mode_halt_out |=> cmd_reject_out)
		else $error("standard write taken outside halt");
	AST_ERROR_STAYS: assert property (mode_error_out && !(cmd_valid_in && cmd_code_in == `CMD_ERR_RESET) |=> mode_error_out)
		else $error("error mode left without reset command");
	AST_WEAR_ALARM: assert property (wear_count_out <= `WEAR_LIMIT |-> !nvm_wear_alarm_flag_out)
		else $error("wear alarm below limit");
	AST_COPY_PAIR: assert property (ee_re_out |-> ##2 (ram_we_out && ram_wdata_out == $past(ee_rdata_in)))
		else $error("eeprom word not copied to ram");
endmodule // plc_mode_ctrl_monitor

bind plc_mode_ctrl plc_mode_ctrl_monitor #(.EXTENDED(EXTENDED)) u_mon (.mclk_in, .resetn_in,
	.cmd_valid_in, .cmd_code_in, .diag_fault_in, .ee_rdata_in, .cmd_accept_out, .cmd_reject_out,
	.mode_run_out, .mode_halt_out, .mode_error_out, .mode_hold_out, .mode_runf_out,
	.exec_enable_out, .io_update_out, .outputs_off_out, .tool_output_write_out, .nvm_busy_out,
	.nvm_wear_alarm_flag_out, .wear_count_out, .ee_re_out, .ram_we_out, .ram_wdata_out);

// ### tb/tb_plc_mode_ctrl.sv
`timescale 1ns/1ps
`include "plc_regs.vh"

// ==================================================
// both variants, short program image to keep copies brief
module tb_plc_mode_ctrl;
	localparam [15:0] PW = 16'h0010;
	localparam [4:0]  M_RUN = 5'h10, M_HALT = 5'h08, M_ERR = 5'h04, M_HOLD = 5'h02, M_RUNF = 5'h01;
	reg          mclk_in, resetn_in, mode_sw_run_in, cmd_valid_in, diag_fault_in, missing_hw_in;
	reg  [3:0]   cmd_code_in;
	reg  [7:0]   fault_cause_in;
	wire [15:0]  ee_rdata, ram_rdata, ee_addr, ee_wdata, ram_addr, ram_wdata, saved_cnt;
	wire [16:0]  wear_cnt;
	wire [7:0]   cause;
	wire         acc, rej, m_run, m_halt, m_err, m_hold, m_runf, exec_en, io_upd, outs_off;
	wire         tool_wr, edit_en, busy, alarm, ee_re, ee_we, ram_re, ram_we;
	wire [15:0]  ee_rdata_x, ram_rdata_x, ee_addr_x, ee_wdata_x, ram_addr_x, ram_wdata_x, saved_x;
	wire         busy_x, ee_re_x, ee_we_x, ram_re_x, ram_we_x;
	wire [4:0]   modes = {m_run, m_halt, m_err, m_hold, m_runf};
	integer      error_cnt = 0;
	integer      total_checks = 0;

	plc_mode_ctrl #(.EXTENDED(0), .PROG_WORDS(PW)) DUT (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.mode_sw_run_in(mode_sw_run_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
		.diag_fault_in(diag_fault_in), .fault_cause_in(fault_cause_in),
		.missing_hw_in(missing_hw_in), .ee_rdata_in(ee_rdata), .ram_rdata_in(ram_rdata),
		.cmd_accept_out(acc), .cmd_reject_out(rej), .mode_run_out(m_run), .mode_halt_out(m_halt),
		.mode_error_out(m_err), .mode_hold_out(m_hold), .mode_runf_out(m_runf),
		.exec_enable_out(exec_en), .io_update_out(io_upd), .outputs_off_out(outs_off),
		.tool_output_write_out(tool_wr), .prog_edit_enable_out(edit_en), .error_cause_out(cause),
		.nvm_busy_out(busy), .saved_data_count_out(saved_cnt), .nvm_wear_alarm_flag_out(alarm),
		.wear_count_out(wear_cnt), .ee_re_out(ee_re), .ee_we_out(ee_we), .ee_addr_out(ee_addr),
		.ee_wdata_out(ee_wdata), .ram_re_out(ram_re), .ram_we_out(ram_we),
		.ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata));
	nvm_store_model mem (.mclk_in(mclk_in), .ee_re_in(ee_re), .ee_we_in(ee_we),
		.ee_addr_in(ee_addr), .ee_wdata_in(ee_wdata), .ram_re_in(ram_re), .ram_we_in(ram_we),
		.ram_addr_in(ram_addr), .ram_wdata_in(ram_wdata), .ee_rdata_out(ee_rdata),
		.ram_rdata_out(ram_rdata));
	plc_mode_ctrl #(.EXTENDED(1), .PROG_WORDS(PW)) dut_ext (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .mode_sw_run_in(mode_sw_run_in), .cmd_valid_in(cmd_valid_in),
		.cmd_code_in(cmd_code_in), .diag_fault_in(diag_fault_in), .fault_cause_in(fault_cause_in),
		.missing_hw_in(missing_hw_in), .ee_rdata_in(ee_rdata_x), .ram_rdata_in(ram_rdata_x),
		.cmd_accept_out(), .cmd_reject_out(), .mode_run_out(), .mode_halt_out(),
		.mode_error_out(), .mode_hold_out(), .mode_runf_out(), .exec_enable_out(),
		.io_update_out(), .outputs_off_out(), .tool_output_write_out(),
		.prog_edit_enable_out(), .error_cause_out(), .nvm_busy_out(busy_x),
		.saved_data_count_out(saved_x), .nvm_wear_alarm_flag_out(), .wear_count_out(),
		.ee_re_out(ee_re_x), .ee_we_out(ee_we_x), .ee_addr_out(ee_addr_x),
		.ee_wdata_out(ee_wdata_x), .ram_re_out(ram_re_x), .ram_we_out(ram_we_x),
		.ram_addr_out(ram_addr_x), .ram_wdata_out(ram_wdata_x));
	nvm_store_model memx (.mclk_in(mclk_in), .ee_re_in(ee_re_x), .ee_we_in(ee_we_x),
		.ee_addr_in(ee_addr_x), .ee_wdata_in(ee_wdata_x), .ram_re_in(ram_re_x),
		.ram_we_in(ram_we_x), .ram_addr_in(ram_addr_x), .ram_wdata_in(ram_wdata_x),
		.ee_rdata_out(ee_rdata_x), .ram_rdata_out(ram_rdata_x));

	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	// ==================================================
	// tasks
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one-cycle strobe, answer looked at in the cycle after taking
	task send(input logic [3:0] code, input logic ok, input logic [4:0] m);
		@(posedge mclk_in);
		cmd_valid_in <= 1'b1;
		cmd_code_in <= code;
		@(posedge mclk_in);
		cmd_valid_in <= 1'b0;
		#1;
		check("accept", acc, ok);
		check("reject", rej, !ok);
		check("mode", modes, m);
	endtask
	task wait_idle;
		integer n;
		n = 0;
		repeat (2) @(posedge mclk_in);
		while ((busy !== 1'b0 || busy_x !== 1'b0) && n < 6000) begin
			@(posedge mclk_in);
			n++;
		end
		if (n == 6000) begin
			error_cnt++;
			$display("CHECK FAILED busy expected 0 seen 1");
			end_of_test;
		end
		repeat (3) @(posedge mclk_in);
		#1;
	endtask
	task sw(input logic pos);
		@(posedge mclk_in);
		mode_sw_run_in <= pos;
		repeat (6) @(posedge mclk_in);
		#1;
	endtask

	// ==================================================
	// main sequence
	initial begin
		resetn_in = 1'b0;
		mode_sw_run_in = 1'b1;
		cmd_valid_in = 1'b0;
		cmd_code_in = 4'h0;
		diag_fault_in = 1'b0;
		fault_cause_in = 8'h00;
		missing_hw_in = 1'b0;
		repeat (10) @(posedge mclk_in);
		resetn_in <= 1'b1;
		wait_idle;
		check("boot mode", modes, M_RUN);
		for (int i = 0; i < PW; i++)
			check("prog copy", mem.ram[i], i[15:0] ^ 16'ha5c3);
		for (int i = 0; i < 512; i++)
			check("data copy", mem.ram[16'h9000 + i], (PW + i[15:0]) ^ 16'ha5c3);
		check("data end", mem.ram[16'h9200], 16'h0000);
		check("saved count", saved_cnt, 16'h0200);
		check("ext count", saved_x, 16'h0800);
		check("ext set", memx.ram[16'h8005], (PW + 16'h0005) ^ 16'ha5c3);
		check("ext data", memx.ram[16'h9000 + 2047], (PW + 16'h0805) ^ 16'ha5c3);
		memx.ram[1] = 16'h1234;
		memx.ram[16'h9000] = 16'h5555;
		send(`CMD_PROG_LOAD, 0, M_RUN);
		send(`CMD_PROG_EDIT, 0, M_RUN);
		send(`CMD_EE_WRITE, 0, M_RUN);
		send(`CMD_EE_READ, 0, M_RUN);
		send(4'hf, 0, M_RUN);
		wait_idle;
		check("ext prog", memx.ee[1], 16'h1234);
		check("ext kept", memx.ee[PW + 16'h0006], (PW + 16'h0006) ^ 16'ha5c3);
		send(`CMD_HOLD, 1, M_HOLD);
		check("hold io", {io_upd, tool_wr, exec_en}, 3'b110);
		send(`CMD_RUN, 0, M_HOLD);
		send(`CMD_HOLD_CANCEL, 1, M_RUN);
		send(`CMD_RUNF, 1, M_RUNF);
		missing_hw_in <= 1'b1;
		sw(1'b1);
		check("runf missing", {modes, exec_en}, {M_RUNF, 1'b1});
		send(`CMD_HALT, 1, M_HALT);
		check("halt outs", {outs_off, exec_en, edit_en}, 3'b101);
		send(`CMD_RUN, 1, M_RUN);
		sw(1'b1);
		check("missing err", {modes, cause}, {M_ERR, `CAUSE_MISSING_HW});
		missing_hw_in <= 1'b0;
		send(`CMD_RUN, 0, M_ERR);
		send(`CMD_ERR_RESET, 1, M_HALT);
		send(`CMD_HOLD, 0, M_HALT);
		send(`CMD_PROG_LOAD, 1, M_HALT);
		send(`CMD_PROG_EDIT, 1, M_HALT);
		// ram edit dropped by a reload
		mem.ram[0] = 16'hbeef;
		send(`CMD_EE_READ, 1, M_HALT);
		wait_idle;
		check("reload", mem.ram[0], 16'ha5c3);
		mem.ram[1] = 16'h1234;
		mem.ram[16'h9000 + 511] = 16'h4321;
		mem.ram[16'h9000 + 512] = 16'h7777;
		memx.ram[16'h8005] = 16'h0003;
		memx.ram[16'h9002] = 16'h6666;
		memx.ram[16'h9003] = 16'h7777;
		send(`CMD_EE_WRITE, 1, M_HALT);
		send(`CMD_EE_READ, 0, M_HALT);
		wait_idle;
		check("wear count", {wear_cnt, alarm}, {17'h00001, 1'b0});
		check("saved prog", mem.ee[1], 16'h1234);
		check("saved last", mem.ee[PW + 511], 16'h4321);
		check("not saved", mem.ee[PW + 512], (PW + 16'h0200) ^ 16'ha5c3);
		check("ext saved", saved_x, 16'h0003);
		check("ext last", memx.ee[PW + 16'h0008], 16'h6666);
		check("ext beyond", memx.ee[PW + 16'h0009], (PW + 16'h0009) ^ 16'ha5c3);
		// mode commands ignored with switch at halt
		sw(1'b0);
		send(`CMD_RUN, 0, M_HALT);
		sw(1'b1);
		check("switch run", modes, M_RUN);
		sw(1'b0);
		check("switch halt", modes, M_HALT);
		sw(1'b1);
		@(posedge mclk_in);
		diag_fault_in <= 1'b1;
		fault_cause_in <= 8'h3c;
		@(posedge mclk_in);
		diag_fault_in <= 1'b0;
		sw(1'b0);
		check("fault", {modes, cause, outs_off}, {M_ERR, 8'h3c, 1'b1});
		sw(1'b1);
		check("err sticky", modes, M_ERR);
		send(`CMD_ERR_RESET, 1, M_HALT);
		// power cycle brings back the stored image, switch at halt
		mem.ram[2] = 16'h0bad;
		@(posedge mclk_in);
		mode_sw_run_in <= 1'b0;
		resetn_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'b1;
		wait_idle;
		check("reboot ram", mem.ram[2], 16'h0002 ^ 16'ha5c3);
		check("reboot mode", modes, M_HALT);
		check("ext reload", saved_x, 16'h0003);
		end_of_test;
	end
endmodule // tb_plc_mode_ctrl
